// [src/fcl_pkg.sv]
// Package: shared constants for the fan commutation, lock and PWM block
package fcl_pkg;
  // ==========================================================
  // Clock and timing
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned PWM_FREQ_HZ = 24_000;
  localparam int unsigned PWM_PERIOD_CYC = CLK_HZ / PWM_FREQ_HZ;
  // Retry and detect times in milliseconds
  localparam int unsigned RETRY_DRIVE_MS = 330;
  localparam int unsigned RETRY_WAIT_MS = 4000;
  localparam int unsigned STALL_DETECT_MS = 2 * RETRY_DRIVE_MS;
  localparam int unsigned MS_CYC = CLK_HZ / 1000;
  localparam int unsigned RETRY_DRIVE_CYC = RETRY_DRIVE_MS * MS_CYC;
  localparam int unsigned RETRY_WAIT_CYC = RETRY_WAIT_MS * MS_CYC;
  localparam int unsigned STALL_DETECT_CYC = STALL_DETECT_MS * MS_CYC;
  // ==========================================================
  // Speed demand code: 8 bits, 0 means 1V (100 %), FULL means 2V (0 %)
  localparam int unsigned DEMAND_W = 8;
  localparam logic [7:0] DEMAND_FULL = 8'hFF;
  localparam logic [7:0] DEMAND_OPEN = 8'h80;
  // ==========================================================
  // Output variants
  typedef enum logic [1:0] {FCL_COMBINED, FCL_STALL_ONLY, FCL_TACH_ONLY} fcl_variant_t;
  typedef enum {FCL_RUN, FCL_DRIVE, FCL_WAIT} fcl_state_t;
endpackage

// [src/fcl_core.sv]
// Fan commutation, PWM speed control and stall protection core
`timescale 1ns/1ps
`default_nettype none
// How it works
// - sensor positive above negative selects phase B
// - active phase gated by duty PWM
// - demand code maps linearly to duty
// - open demand input gives half duty
// - with internal PWM, demand at full scale forces drive off
// - stall/tach output only pulls low or releases
// - combined variant toggles twice per revolution
// - combined variant released high during stall
// - stall-only variant low normally, high stalled
// - tach-only variant inverted sensor copy
// - stalled: long wait, short drive, retry
// - detect time twice drive time
// - drive 0.33 s, wait 4.0 s
// - PWM period from oscillator, about 24 kHz
module fcl_core #(
  parameter fcl_pkg::fcl_variant_t VARIANT = fcl_pkg::FCL_COMBINED,
  parameter int unsigned DETECT_CYC = fcl_pkg::STALL_DETECT_CYC,
  parameter int unsigned DRIVE_CYC = fcl_pkg::RETRY_DRIVE_CYC,
  parameter int unsigned WAIT_CYC = fcl_pkg::RETRY_WAIT_CYC
) (
  input wire logic CLK, // 40 MHz clock
  input wire logic RST_N, // Asynchronous reset, active low
  input wire logic SENSOR_POS_ABOVE, // Comparator: positive sensor input above negative
  input wire logic [7:0] SPEED_DEMAND_IN, // Demand code, 00 = 1V full, FF = 2V off
  input wire logic SPEED_DEMAND_OPEN, // High when nothing drives the demand input
  input wire logic EXT_PWM_SEL, // High selects external PWM on the timer node
  input wire logic EXT_PWM_IN, // External digital PWM
  output logic PHASE_A_DRIVE, // First phase drive, high = on
  output logic PHASE_B_DRIVE, // Second phase drive, high = on
  output logic STALL_TACH_OE, // Pull-low enable of stall/tach pin
  output logic STALL_TACH_O, // Pin output value, always low
  output logic STALLED // Stall state flag
);
  // ==========================================================
  // Input synchronisers: stage one read only by stage two
  logic [3:0] sync1;
  logic [3:0] sync2;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      sync1 <= 4'h0;
      sync2 <= 4'h0;
    end else begin
      sync1 <= {SENSOR_POS_ABOVE, SPEED_DEMAND_OPEN, EXT_PWM_SEL, EXT_PWM_IN};
      sync2 <= sync1;
    end
  end
  logic hall;
  logic demand_open;
  logic ext_sel;
  logic ext_pwm;
  assign {hall, demand_open, ext_sel, ext_pwm} = sync2;
  // Demand bus is a slow analog conversion; two stages keep metastability out
  logic [7:0] dem1;
  logic [7:0] dem2;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      dem1 <= 8'h0;
      dem2 <= 8'h0;
    end else begin
      dem1 <= SPEED_DEMAND_IN;
      dem2 <= dem1;
    end
  end
  // ==========================================================
  // Sensor edge detection on the synchronised level
  logic hall_d;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      hall_d <= 1'b0;
    end else begin
      hall_d <= hall;
    end
  end
  logic hall_edge;
  assign hall_edge = hall ^ hall_d;
  // ==========================================================
  // PWM oscillator, a free counter standing in for the ramp capacitor
  localparam int unsigned PER = fcl_pkg::PWM_PERIOD_CYC;
  logic [10:0] pwm_cnt;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pwm_cnt <= 11'h0;
    end else if (pwm_cnt == 11'(PER - 1)) begin
      pwm_cnt <= 11'h0;
    end else begin
      pwm_cnt <= pwm_cnt + 11'h1;
    end
  end
  // Effective demand: open input falls back to mid code
  logic [7:0] demand;
  assign demand = demand_open ? fcl_pkg::DEMAND_OPEN : dem2;
  // On-time = (FULL - demand) / FULL of the period
  logic [18:0] on_prod;
  logic [10:0] on_cyc;
  assign on_prod = 19'(fcl_pkg::DEMAND_FULL - demand) * 19'(PER);
  assign on_cyc = 11'(on_prod / 19'(fcl_pkg::DEMAND_FULL));
  logic pwm_on;
  // With internal PWM, full-scale demand gives zero on-time, so the drive is forced off
  assign pwm_on = ext_sel ? ext_pwm : (pwm_cnt < on_cyc);
  // ==========================================================
  // Stall detector and retry sequencer
  fcl_pkg::fcl_state_t state;
  logic [27:0] tmr;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state <= fcl_pkg::FCL_RUN;
      tmr <= 28'h0;
    end else begin
      case (state)
        fcl_pkg::FCL_RUN: begin
          if (hall_edge) begin
            tmr <= 28'h0;
          end else if (tmr >= 28'(DETECT_CYC - 1)) begin
            state <= fcl_pkg::FCL_WAIT;
            tmr <= 28'h0;
          end else begin
            tmr <= tmr + 28'h1;
          end
        end
        fcl_pkg::FCL_DRIVE: begin
          if (hall_edge) begin
            state <= fcl_pkg::FCL_RUN;
            tmr <= 28'h0;
          end else if (tmr >= 28'(DRIVE_CYC - 1)) begin
            state <= fcl_pkg::FCL_WAIT;
            tmr <= 28'h0;
          end else begin
            tmr <= tmr + 28'h1;
          end
        end
        fcl_pkg::FCL_WAIT: begin
          if (hall_edge) begin
            state <= fcl_pkg::FCL_RUN;
            tmr <= 28'h0;
          end else if (tmr >= 28'(WAIT_CYC - 1)) begin
            state <= fcl_pkg::FCL_DRIVE;
            tmr <= 28'h0;
          end else begin
            tmr <= tmr + 28'h1;
          end
        end
        default: begin
          state <= fcl_pkg::FCL_RUN;
          tmr <= 28'h0;
        end
      endcase
    end
  end
  // ==========================================================
  // Phase drive: waiting holds both off
  logic drive_ok;
  assign drive_ok = (state != fcl_pkg::FCL_WAIT) && pwm_on;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      PHASE_A_DRIVE <= 1'b0;
      PHASE_B_DRIVE <= 1'b0;
    end else begin
      PHASE_B_DRIVE <= drive_ok && hall;
      PHASE_A_DRIVE <= drive_ok && !hall;
    end
  end
  // ==========================================================
  // Stall/tach pin: open collector, released pin reads high
  logic stalled;
  assign stalled = (state != fcl_pkg::FCL_RUN);
  logic next_release;
  always_comb begin
    case (VARIANT)
      fcl_pkg::FCL_COMBINED: next_release = stalled ? 1'b1 : hall;
      fcl_pkg::FCL_STALL_ONLY: next_release = stalled;
      fcl_pkg::FCL_TACH_ONLY: next_release = !hall;
      default: next_release = 1'b1;
    endcase
  end
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      STALL_TACH_OE <= 1'b0;
      STALL_TACH_O <= 1'b0;
      STALLED <= 1'b0;
    end else begin
      STALL_TACH_OE <= !next_release;
      STALL_TACH_O <= 1'b0;
      STALLED <= stalled;
    end
  end
  // ==========================================================
  // Checks
  one_phase_a: assert property (@(posedge CLK) disable iff (!RST_N)
    !(PHASE_A_DRIVE && PHASE_B_DRIVE)) else $error("both phases on");
  phase_b_sel_a: assert property (@(posedge CLK) disable iff (!RST_N)
    PHASE_B_DRIVE |-> $past(hall)) else $error("phase B without sensor high");
  phase_a_sel_a: assert property (@(posedge CLK) disable iff (!RST_N)
    PHASE_A_DRIVE |-> !$past(hall)) else $error("phase A with sensor high");
  full_off_a: assert property (@(posedge CLK) disable iff (!RST_N)
    ($past(demand) == fcl_pkg::DEMAND_FULL && !$past(ext_sel)) |-> !PHASE_A_DRIVE && !PHASE_B_DRIVE)
    else $error("drive on at full demand");
  pin_low_a: assert property (@(posedge CLK) disable iff (!RST_N)
    STALL_TACH_O == 1'b0) else $error("pin driven high");
  wait_off_a: assert property (@(posedge CLK) disable iff (!RST_N)
    $past(state == fcl_pkg::FCL_WAIT) |-> !PHASE_A_DRIVE && !PHASE_B_DRIVE)
    else $error("drive during wait");
  resume_run_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (stalled && hall_edge) |=> state == fcl_pkg::FCL_RUN) else $error("no resume");
  stall_rel_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (VARIANT != fcl_pkg::FCL_TACH_ONLY && stalled) |=> !STALL_TACH_OE)
    else $error("pin low while stalled");
  stall_detect_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (state == fcl_pkg::FCL_RUN && !hall_edge && tmr == 28'(DETECT_CYC - 1)) |=> state == fcl_pkg::FCL_WAIT)
    else $error("stall not detected");
endmodule // fcl_core
`default_nettype wire

// [bench/fcl_hall_model.sv]
// Rotor sensor model for the fan core bench
`timescale 1ns/1ps
`default_nettype none
module fcl_hall_model #(
  parameter int unsigned HALF_CYC = 20
) (
  input wire logic clk, // Bench clock
  input wire logic spin, // High while the rotor turns
  output logic sensor // High = positive input above negative
);
  int unsigned cnt = 0;
  logic level = 1'b0;
  // ========================================
  // Rotor motion: a locked rotor freezes the level, so no edge hides a stall
  always @(posedge clk) begin
    if (spin) begin
      cnt <= (cnt + 1 == HALF_CYC) ? 0 : cnt + 1;
      if (cnt + 1 == HALF_CYC) begin
        level <= ~level;
      end
    end
  end
  // One driver for the sensor output
  assign sensor = level;
endmodule // fcl_hall_model
`default_nettype wire

// [bench/fcl_core_tb_top.sv]
// Testbench for the fan commutation, PWM and stall core
`timescale 1ns/1ps
`default_nettype none
module fcl_core_tb_top;
  localparam int unsigned DET = 50;
  localparam int unsigned DRV = 20;
  localparam int unsigned WT = 100;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic spin = 1'b0;
  logic sensor;
  logic [7:0] dem = 8'h00;
  logic opn = 1'b0;
  logic esel = 1'b0;
  logic ein = 1'b0;
  logic pa, pb, oe, oo, oe_s, oe_t, stl;
  int error_cnt = 0;
  int checked = 0;
  // ========================================
  // Clock, rotor and three output variants fed alike
  always #12.5 clk = ~clk;
  fcl_hall_model #(.HALF_CYC(20)) hall (.clk(clk), .spin(spin), .sensor(sensor));
  fcl_core #(.VARIANT(fcl_pkg::FCL_COMBINED), .DETECT_CYC(DET), .DRIVE_CYC(DRV), .WAIT_CYC(WT)) DUT (.CLK(clk),
    .RST_N(rst_n), .SENSOR_POS_ABOVE(sensor), .SPEED_DEMAND_IN(dem), .SPEED_DEMAND_OPEN(opn), .EXT_PWM_SEL(esel),
    .EXT_PWM_IN(ein), .PHASE_A_DRIVE(pa), .PHASE_B_DRIVE(pb), .STALL_TACH_OE(oe), .STALL_TACH_O(oo), .STALLED(stl));
  fcl_core #(.VARIANT(fcl_pkg::FCL_STALL_ONLY), .DETECT_CYC(DET), .DRIVE_CYC(DRV), .WAIT_CYC(WT)) DUT_S (.CLK(clk),
    .RST_N(rst_n), .SENSOR_POS_ABOVE(sensor), .SPEED_DEMAND_IN(dem), .SPEED_DEMAND_OPEN(opn), .EXT_PWM_SEL(esel),
    .EXT_PWM_IN(ein), .PHASE_A_DRIVE(), .PHASE_B_DRIVE(), .STALL_TACH_OE(oe_s), .STALL_TACH_O(), .STALLED());
  fcl_core #(.VARIANT(fcl_pkg::FCL_TACH_ONLY), .DETECT_CYC(DET), .DRIVE_CYC(DRV), .WAIT_CYC(WT)) DUT_T (.CLK(clk),
    .RST_N(rst_n), .SENSOR_POS_ABOVE(sensor), .SPEED_DEMAND_IN(dem), .SPEED_DEMAND_OPEN(opn), .EXT_PWM_SEL(esel),
    .EXT_PWM_IN(ein), .PHASE_A_DRIVE(), .PHASE_B_DRIVE(), .STALL_TACH_OE(oe_t), .STALL_TACH_O(), .STALLED());
  // ========================================
  // Verdict and comparison helpers
  task automatic test_done();
    if (error_cnt == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input int lo, input int hi, input logic [15:0] got);
    checked++;
    // Signed compare: a lower bound below zero must not wrap to a huge unsigned value
    if ($isunknown(got) || int'(got) < lo || int'(got) > hi) begin
      error_cnt++;
      $display("FAIL %s exp %0d..%0d got %0d", nm, lo, hi, got);
    end
  endtask
  // Expected on-cycles per PWM period, linear from full drive at 00 to none at FF
  function automatic int duty_cyc(input int code);
    return (int'(fcl_pkg::DEMAND_FULL) - code) * int'(fcl_pkg::PWM_PERIOD_CYC) / int'(fcl_pkg::DEMAND_FULL);
  endfunction
  // Bounded wait for pa (sel 1) or stl (sel 0) to reach v; a hang ends the run
  task automatic wait_for(input bit sel, input logic v, input int lim, output int n);
    for (n = 0; (sel ? pa : stl) !== v; n++) begin
      if (n >= lim) begin
        error_cnt++;
        $display("FAIL wait exp %b got timeout", v);
        test_done();
      end
      @(posedge clk);
    end
  endtask
  // Spin until the sensor just flipped to v, then lock the rotor
  task automatic set_lvl(input logic v);
    logic last;
    last = sensor;
    spin <= 1'b1;
    for (int n = 0; n < 100; n++) begin
      @(posedge clk);
      if (sensor === v && last !== v) break;
      last = sensor;
    end
    spin <= 1'b0;
    chk("sensor level", 1, 1, {15'h0, sensor === v});
  endtask
  // ========================================
  // Scenarios
  task automatic t_commute();
    for (int v = 0; v < 2; v++) begin
      set_lvl(v[0]);
      repeat (6) @(posedge clk);
      chk("phase b", v, v, {15'h0, pb});
      chk("phase a", 1 - v, 1 - v, {15'h0, pa});
      chk("combined pin", v, v, {15'h0, ~oe});
      chk("tach pin", 1 - v, 1 - v, {15'h0, ~oe_t});
      chk("stall-only pin", 0, 0, {15'h0, ~oe_s});
      chk("pin value", 0, 0, {15'h0, oo});
    end
  endtask
  task automatic t_duty(input logic [7:0] code, input logic open_in, input int exp);
    int on;
    on = 0;
    dem <= code;
    opn <= open_in;
    spin <= 1'b1;
    repeat (30) @(posedge clk);
    repeat (fcl_pkg::PWM_PERIOD_CYC) begin
      @(posedge clk);
      if ((pa | pb) === 1'b1) on++;
    end
    chk("duty", exp - 8, exp + 8, on[15:0]);
  endtask
  task automatic t_stall();
    int n;
    dem <= 8'h00;
    set_lvl(1'b0);
    wait_for(0, 1'b1, DET + 20, n);
    chk("detect time", DET - 2, DET + 8, n[15:0]);
    @(posedge clk);
    chk("wait drive", 0, 0, {15'h0, pa | pb});
    chk("combined stall pin", 1, 1, {15'h0, ~oe});
    chk("stall-only stall pin", 1, 1, {15'h0, ~oe_s});
    wait_for(1, 1'b1, WT + 20, n);
    chk("retry wait", WT - 4, WT + 3, n[15:0]);
    chk("pin in retry", 1, 1, {15'h0, ~oe});
    wait_for(1, 1'b0, DRV + 20, n);
    chk("retry drive", DRV - 3, DRV + 3, n[15:0]);
    spin <= 1'b1;
    wait_for(0, 1'b0, 40, n);
    set_lvl(1'b1);
    repeat (6) @(posedge clk);
    chk("resumed pin", 1, 1, {15'h0, ~oe});
    chk("resumed drive", 1, 1, {15'h0, pb});
    chk("resumed flag", 0, 0, {15'h0, stl});
  endtask
  // ========================================
  // Main sequence: reset, then every scenario
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_commute();
    t_duty(8'h00, 1'b0, duty_cyc(8'h00));
    t_duty(8'h40, 1'b0, duty_cyc(8'h40));
    t_duty(8'hFF, 1'b0, 0);
    t_duty(8'hFF, 1'b1, duty_cyc(int'(fcl_pkg::DEMAND_OPEN)));
    esel <= 1'b1;
    t_duty(8'h00, 1'b1, 0);
    ein <= 1'b1;
    t_duty(8'h00, 1'b1, fcl_pkg::PWM_PERIOD_CYC);
    esel <= 1'b0;
    t_stall();
    test_done();
  end
endmodule // fcl_core_tb_top
`default_nettype wire
